// >>> src/liu_rx_pkg.sv
package liu_rx_pkg;

	localparam int CHANNELS = 14;

	// register byte offsets
	localparam logic [7:0] ADDR_CONTROL       = 8'h00;
	localparam logic [7:0] ADDR_POWER         = 8'h04;
	localparam logic [7:0] ADDR_TERMINATION   = 8'h08;
	localparam logic [7:0] ADDR_COUNTER_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_STATUS        = 8'h10;
	localparam logic [7:0] ADDR_MASK          = 8'h14;
	localparam logic [7:0] ADDR_LIVE          = 8'h18;

	// status and mask layout: los events low, overflow events above
	localparam int STATUS_LOS_LSB = 0;
	localparam int STATUS_OVF_LSB = 14;
	localparam int STATUS_WIDTH   = 28;

	// reset values
	localparam logic [3:0]  CONTROL_RESET     = 4'h0;
	localparam logic [13:0] POWER_RESET       = 14'h0000;
	localparam logic [13:0] TERMINATION_RESET = 14'h0000;
	localparam logic [15:0] COUNT_SATURATED   = 16'hFFFF;

	// timing: internal master clock half period
	localparam int CLOCK_PERIOD_NS    = 4;
	localparam int MASTER_HALF_NS     = 324;
	localparam int MASTER_HALF_CYCLES = MASTER_HALF_NS / CLOCK_PERIOD_NS;
	localparam int LOS_HOLD_CYCLES    = 2 * MASTER_HALF_CYCLES;

	// global control bits, bit 0 is handover
	typedef struct packed {
		logic overflow_select;
		logic single_rail;
		logic edge_select;
		logic handover;
	} control_t;

	// line-side inputs, one bit per channel
	typedef struct packed {
		logic [CHANNELS-1:0] clock;
		logic [CHANNELS-1:0] pos;
		logic [CHANNELS-1:0] neg;
		logic [CHANNELS-1:0] los;
		logic [CHANNELS-1:0] violation;
	} line_t;

endpackage : liu_rx_pkg

// >>> src/liu_receive_output_control.sv
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
// Operation
// R1: receivers start powered off after reset
// R2: enable pin high lets register bits power receivers
// R3: enable pin low forces every receiver off
// R4: termination starts off, register bit enables it
// R5: handover bit one passes termination to pin
// R6: under pin control, pin high terminates
// R7: any channel los raises summary one clock minimum
// R8: summary stays high until los clears
// R9: recovered clock falls back to master clock
// R10: rail data change on selected clock edge
// R11: edge select is one global control
// R12: positive rail carries pulses or nrz data
// R13: dual rail negative output carries negative pulses
// R14: single rail negative output is selected flag
// R15: violation flag rises on any violation
// R16: violation flag holds while violations continue
// R17: overflow flag holds until counter reset
// R18: channels independent, only summary and globals shared
module liu_receive_output_control
	import liu_rx_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// control pins
	input  wire logic                receive_power_enable_pin,
	input  wire logic                rx_termination_select_pin,
	// line side, per channel
	input  wire logic [CHANNELS-1:0] line_clock,
	input  wire logic [CHANNELS-1:0] line_pos,
	input  wire logic [CHANNELS-1:0] line_neg,
	input  wire logic [CHANNELS-1:0] line_los,
	input  wire logic [CHANNELS-1:0] line_violation,
	// receiver control
	output logic      [CHANNELS-1:0] receiver_on,
	output logic      [CHANNELS-1:0] termination_on,
	// framer side
	output logic      [CHANNELS-1:0] recovered_clock,
	output logic      [CHANNELS-1:0] positive_rail_data,
	output logic      [CHANNELS-1:0] negative_rail_data,
	output logic                     loss_of_signal_summary,
	// interrupt
	output logic                     irq
);

	// registers and bus state
	control_t                  control;
	logic [CHANNELS-1:0]       power_reg;
	logic [CHANNELS-1:0]       term_reg;
	logic [STATUS_WIDTH-1:0]   status;
	logic [STATUS_WIDTH-1:0]   mask;
	logic                      wr_pend;
	logic [7:0]                wr_addr;

	// synchronised inputs and derived state
	line_t                     line_s1;
	line_t                     line_s2;
	line_t                     line_raw;
	logic [1:0]                pin_s1;
	logic [1:0]                pin_s2;
	logic [CHANNELS-1:0]       los_prev;
	logic [CHANNELS-1:0]       ovf_prev;
	logic [CHANNELS-1:0]       ovf;
	logic [CHANNELS-1:0]       rx_on;
	logic [7:0]                master_count;
	logic                      master_tick;
	logic [8:0]                los_hold;

	// input synchronisers: every line and pin input passes two flops
	// before any logic reads it; the first stage is read by nothing else
	// grouped so the whole line side shares one pair of flop stages
	assign line_raw = '{
		clock:     line_clock,
		pos:       line_pos,
		neg:       line_neg,
		los:       line_los,
		violation: line_violation
	};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_s1 <= '0;
			line_s2 <= '0;
			pin_s1  <= 2'h0;
			pin_s2  <= 2'h0;
		end else begin
			line_s1 <= line_raw;
			line_s2 <= line_s1;
			pin_s1  <= {rx_termination_select_pin, receive_power_enable_pin};
			pin_s2  <= pin_s1;
		end
	end

	// bit 0 carries the enable pin, bit 1 the termination select pin
	wire enable_pin = pin_s2[0];
	wire term_pin   = pin_s2[1];

	// ahb-lite slave, zero wait states, response always okay
	//
	// byte map, one word per register, upper bits read zero:
	//   00 control: 0 handover, 1 edge select, 2 single rail,
	//      3 overflow select
	//   04 receiver power, one bit per channel
	//   08 termination, one bit per channel
	//   0c counter clear, write one to clear, reads zero
	//   10 status: los rise low, counter saturation above, w1c
	//   14 mask, same layout as status
	//   18 live los levels, read only
	// anything else reads zero and ignores writes
	// writes land in the data phase, one edge after the address
	// phase, so a read right behind a write sees the old value
	wire addr_take = hsel & hready & htrans[1];
	wire read_take = addr_take & ~hwrite;

	wire wr_control = wr_pend & (wr_addr == ADDR_CONTROL);
	wire wr_power   = wr_pend & (wr_addr == ADDR_POWER);
	wire wr_term    = wr_pend & (wr_addr == ADDR_TERMINATION);
	wire wr_clear   = wr_pend & (wr_addr == ADDR_COUNTER_CLEAR);
	wire wr_status  = wr_pend & (wr_addr == ADDR_STATUS);
	wire wr_mask    = wr_pend & (wr_addr == ADDR_MASK);

	wire [7:0] rd_addr = haddr[7:0];
	wire       rd_hit  = (haddr[31:8] == 24'h000000);

	wire [31:0] rd_control = {28'h0000000, control};
	wire [31:0] rd_power   = {18'h00000, power_reg};
	wire [31:0] rd_term    = {18'h00000, term_reg};
	wire [31:0] rd_status  = {4'h0, status};
	wire [31:0] rd_mask    = {4'h0, mask};
	wire [31:0] rd_live    = {18'h00000, line_s2.los};

	// unmapped offsets and any address above the block read zero
	wire [31:0] read_mux =
		~rd_hit                       ? 32'h00000000 :
		(rd_addr == ADDR_CONTROL)     ? rd_control :
		(rd_addr == ADDR_POWER)       ? rd_power :
		(rd_addr == ADDR_TERMINATION) ? rd_term :
		(rd_addr == ADDR_STATUS)      ? rd_status :
		(rd_addr == ADDR_MASK)        ? rd_mask :
		(rd_addr == ADDR_LIVE)        ? rd_live :
		32'h00000000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			// hresp and hreadyout never change after reset
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			// a write only records its address here; the data arrive a cycle later
			wr_pend <= addr_take & hwrite & rd_hit;
			if (addr_take) begin
				wr_addr <= rd_addr;
			end
			// hrdata is loaded when a read address phase is taken and then held,
			// so the master may sample it anywhere in the data phase
			if (read_take) begin
				hrdata <= read_mux;
			end
		end
	end

	// global and per-channel control registers
	// writes take the whole word whatever hsize says; narrow writes are
	// not supported
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			control   <= CONTROL_RESET;
			power_reg <= POWER_RESET; // R1
			term_reg  <= TERMINATION_RESET; // R4
			mask      <= '0;
		end else begin
			if (wr_control) begin
				control <= hwdata[3:0]; // R11
			end
			if (wr_power) begin
				power_reg <= hwdata[CHANNELS-1:0];
			end
			if (wr_term) begin
				term_reg <= hwdata[CHANNELS-1:0];
			end
			// mask bits gate irq only; status bits set regardless
			if (wr_mask) begin
				mask <= hwdata[STATUS_WIDTH-1:0];
			end
		end
	end

	// gating from the pins is registered so both outputs come from flops
	assign rx_on = enable_pin ? power_reg : '0; // R2 R3

	// with handover set every channel follows the one pin; the register
	// bits keep their value and apply again when handover is cleared
	wire [CHANNELS-1:0] next_term =
		control.handover ? {CHANNELS{term_pin}} : term_reg; // R5 R6

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			receiver_on    <= '0;
			termination_on <= '0;
		end else begin
			// both lag the pins by three edges: two sync stages, one register
			receiver_on    <= rx_on;
			termination_on <= next_term;
		end
	end

	// internal master clock: one tick per half period
	// the divider free-runs from reset so a channel that loses its line
	// clock finds the fallback already running; the switch-over may
	// shorten one half period, which the framer must tolerate
	localparam logic [7:0] MASTER_LAST = 8'(MASTER_HALF_CYCLES - 1);
	localparam logic [8:0] LOS_LAST    = 9'(LOS_HOLD_CYCLES - 1);

	// tick is combinational from the counter, read in the same edge
	assign master_tick = (master_count == MASTER_LAST);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			master_count <= 8'h00;
		end else if (master_tick) begin
			master_count <= 8'h00;
		end else begin
			master_count <= master_count + 8'h01;
		end
	end

	// global loss-of-signal summary
	// a short los blip is stretched to a full recovered clock period
	// counts all channels, powered or not, so a dead line is reported even
	// before software turns its receiver on
	wire any_los = |line_s2.los;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			los_hold               <= 9'h000;
			loss_of_signal_summary <= 1'b0;
		end else begin
			// reloaded on every cycle with los, so the stretch counts from the last
			if (any_los) begin
				los_hold <= LOS_LAST; // R7
			end else if (los_hold != 9'h000) begin
				los_hold <= los_hold - 9'h001;
			end
			loss_of_signal_summary <= any_los | (los_hold != 9'h000); // R7 R8
		end
	end

	// per-channel clock and data path
	// each copy owns its clock, flag and counter; only the pins, the
	// control word, the master clock tick and the summary are shared
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_channel // R18
			logic [15:0] count;
			logic        viol_seen;

			// the line clock is sampled as data, never used as a clock, so
			// every output stays in the clk domain
			wire active   = rx_on[i] & ~line_s2.los[i];
			wire toggled  = master_tick ? ~recovered_clock[i] : recovered_clock[i];
			wire next_clk = active ? line_s2.clock[i] : toggled; // R9
			// edge_select 0 updates on rising, 1 on falling
			wire update   = (next_clk != recovered_clock[i]) &
				(next_clk == ~control.edge_select); // R10 R11
			wire viol_now = viol_seen | line_s2.violation[i];
			wire saturate = (count == COUNT_SATURATED);
			wire clear    = wr_clear & hwdata[i];

			wire next_pos = control.single_rail ?
				(line_s2.pos[i] | line_s2.neg[i]) : line_s2.pos[i]; // R12
			wire flag     = control.overflow_select ? saturate : viol_now; // R14
			wire next_neg = control.single_rail ? flag : line_s2.neg[i]; // R13 R14

			assign ovf[i] = saturate;

			always_ff @(posedge clk or posedge reset) begin
				// registered so the framer never sees a combinational clock
				if (reset) begin
					recovered_clock[i] <= 1'b0;
				end else begin
					recovered_clock[i] <= next_clk;
				end
			end

			// violations between two update edges are not lost
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					viol_seen <= 1'b0;
				end else if (update) begin
					viol_seen <= 1'b0;
				end else begin
					viol_seen <= viol_now;
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				// clear wins over a count in the same cycle; the counter stops at
				// its ceiling rather than wrapping, so the flag cannot fall by itself
				if (reset) begin
					count <= 16'h0000;
				end else if (clear) begin
					count <= 16'h0000; // R17
				end else if (update & viol_now & ~saturate) begin
					count <= count + 16'h0001;
				end
			end

			// flag sampled per recovered clock: one period minimum, held while
			// violations keep arriving
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					positive_rail_data[i] <= 1'b0;
				end else if (update) begin
					positive_rail_data[i] <= rx_on[i] & next_pos; // R10 R12
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					negative_rail_data[i] <= 1'b0;
				end else if (update) begin
					negative_rail_data[i] <= rx_on[i] & next_neg; // R15 R16 R17
				end
			end
		end
	endgenerate

	// interrupt status: set wins over write-one-to-clear
	// irq is taken from the next status so it rises in the same edge as
	// the status bit it reports
	// rising edges only, so a level that stays high is reported once
	wire [CHANNELS-1:0] los_rise = line_s2.los & ~los_prev;
	wire [CHANNELS-1:0] ovf_rise = ovf & ~ovf_prev;

	wire [STATUS_WIDTH-1:0] events    = {ovf_rise, los_rise};
	wire [STATUS_WIDTH-1:0] clear_w1c = wr_status ? hwdata[STATUS_WIDTH-1:0] : '0;
	wire [STATUS_WIDTH-1:0] next_status = (status & ~clear_w1c) | events;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			los_prev <= '0;
			ovf_prev <= '0;
			status   <= '0;
			irq      <= 1'b0;
		end else begin
			los_prev <= line_s2.los;
			ovf_prev <= ovf;
			status   <= next_status;
			irq      <= |(next_status & mask);
		end
	end

endmodule : liu_receive_output_control

// >>> bench/liu_receive_output_control_sva.sv
`timescale 1ns/100ps
module liu_receive_output_control_sva
	import liu_rx_pkg::*;
(
	// clock and reset
	input wire logic                clk,
	input wire logic                reset,
	// pins and line
	input wire logic                receive_power_enable_pin,
	input wire logic [CHANNELS-1:0] line_los,
	// outputs watched
	input wire logic [CHANNELS-1:0] receiver_on,
	input wire logic [CHANNELS-1:0] termination_on,
	input wire logic [CHANNELS-1:0] recovered_clock,
	input wire logic [CHANNELS-1:0] positive_rail_data,
	input wire logic [CHANNELS-1:0] negative_rail_data,
	input wire logic                loss_of_signal_summary
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// pin passes two sync stages and one output register
	sequence s_pin_low;
		!receive_power_enable_pin [*4];
	endsequence
	sequence s_los_seen;
		(|line_los) [*4];
	endsequence
	a_power_forced_off: assert property (s_pin_low |=> receiver_on == '0)
		else $error("receiver on while enable pin low");
	a_start_off: assert property ($fell(reset) |-> receiver_on == '0 && termination_on == '0)
		else $error("receiver or termination on after reset");
	a_los_raises: assert property (s_los_seen |=> loss_of_signal_summary)
		else $error("summary low during loss of signal");
	a_los_holds: assert property (loss_of_signal_summary && |line_los |=> loss_of_signal_summary)
		else $error("summary fell while loss persists");
	a_los_min_high: assert property ($rose(loss_of_signal_summary) |=> loss_of_signal_summary [*8])
		else $error("summary pulse too short");
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		a_pos_on_edge: assert property ($changed(positive_rail_data[i]) |-> $changed(recovered_clock[i]))
			else $error("positive rail changed off clock edge");
		a_neg_on_edge: assert property ($changed(negative_rail_data[i]) |-> $changed(recovered_clock[i]))
			else $error("negative rail changed off clock edge");
		// the master clock fallback toggles every 81 cycles
		a_clock_runs: assert property (1'b1 |-> ##[1:200] $changed(recovered_clock[i]))
			else $error("recovered clock stopped");
	end
endmodule : liu_receive_output_control_sva

bind liu_receive_output_control liu_receive_output_control_sva chk (
	.clk(clk), .reset(reset), .receive_power_enable_pin(receive_power_enable_pin),
	.line_los(line_los), .receiver_on(receiver_on), .termination_on(termination_on),
	.recovered_clock(recovered_clock), .positive_rail_data(positive_rail_data),
	.negative_rail_data(negative_rail_data), .loss_of_signal_summary(loss_of_signal_summary));

// >>> bench/liu_framer_model.sv
`timescale 1ns/100ps
module liu_framer_model (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// channel 0 as seen by the framer
	input wire logic        recovered_clock,
	input wire logic        positive_rail_data,
	// edge statistics
	output int              rise_updates,
	output int              fall_updates,
	output int              clock_edges
);
	logic prev_clock;
	logic prev_data;
	// data and clock move in the same cycle, so the new clock level tells the edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_clock <= 1'b0;
			prev_data <= 1'b0;
			rise_updates <= 0;
			fall_updates <= 0;
			clock_edges <= 0;
		end else begin
			prev_clock <= recovered_clock;
			prev_data <= positive_rail_data;
			if (recovered_clock != prev_clock)
				clock_edges <= clock_edges + 1;
			if (positive_rail_data != prev_data && recovered_clock)
				rise_updates <= rise_updates + 1;
			if (positive_rail_data != prev_data && !recovered_clock)
				fall_updates <= fall_updates + 1;
		end
	end
endmodule : liu_framer_model

// >>> bench/liu_receive_output_control_test.sv
`timescale 1ns/100ps
module liu_receive_output_control_test
	import liu_rx_pkg::*;
;
	logic clk, reset, hwrite, hreadyout, hresp, power_pin, term_pin, summary, irq, toggling;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [CHANNELS-1:0] line_clock, line_pos, line_neg, line_los, line_violation;
	logic [CHANNELS-1:0] receiver_on, termination_on, rclk, pos, neg;
	int fail_count, compares, rise_updates, fall_updates, clock_edges, s0, s1, lcnt;

	liu_receive_output_control dut (
		.clk(clk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.receive_power_enable_pin(power_pin), .rx_termination_select_pin(term_pin),
		.line_clock(line_clock), .line_pos(line_pos), .line_neg(line_neg),
		.line_los(line_los), .line_violation(line_violation), .receiver_on(receiver_on),
		.termination_on(termination_on), .recovered_clock(rclk), .positive_rail_data(pos),
		.negative_rail_data(neg), .loss_of_signal_summary(summary), .irq(irq));
	liu_framer_model framer (
		.clk(clk), .reset(reset), .recovered_clock(rclk[0]), .positive_rail_data(pos[0]),
		.rise_updates(rise_updates), .fall_updates(fall_updates), .clock_edges(clock_edges));

	task finish_test;
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task wait_ready;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			if (hreadyout === 1'b1)
				return;
		end
		fail_count++;
		finish_test();
	endtask : wait_ready
	// single word transfer; read data lands in rd
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task edges_in(input int n, output int d);
		s1 = clock_edges;
		tick(n);
		d = clock_edges - s1;
	endtask : edges_in

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// 32 ns line clock; data toggles only when asked
	always @(posedge clk) begin
		lcnt <= lcnt + 1;
		if (lcnt[1:0] == 2'h3)
			line_clock <= ~line_clock;
		if (toggling && lcnt[3:0] == 4'hF)
			line_pos <= ~line_pos;
	end

	initial begin
		{reset, hwrite, htrans, haddr, hwdata, power_pin, term_pin, toggling} = '0;
		reset = 1'b1;
		{line_clock, line_pos, line_neg, line_los, line_violation} = '0;
		lcnt = 0;
		tick(16);
		reset <= 1'b0;
		tick(2);
		chk(32'({receiver_on, termination_on, summary, irq}), 32'h0);
		bus(1'b0, ADDR_POWER, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		bus(1'b1, 8'h1C, 32'hFFFF);
		bus(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, ADDR_POWER, 32'h3FFF);
		tick(8);
		chk(32'(receiver_on), 32'h0);
		power_pin <= 1'b1;
		tick(8);
		chk(32'(receiver_on), 32'h3FFF);
		bus(1'b1, ADDR_POWER, 32'h1005);
		tick(8);
		chk(32'(receiver_on), 32'h1005);
		bus(1'b1, ADDR_POWER, 32'h3FFF);
		bus(1'b1, ADDR_TERMINATION, 32'h00A5);
		term_pin <= 1'b1;
		tick(8);
		chk(32'(termination_on), 32'h00A5);
		bus(1'b1, ADDR_CONTROL, 32'h1);
		tick(8);
		chk(32'(termination_on), 32'h3FFF);
		term_pin <= 1'b0;
		tick(8);
		chk(32'(termination_on), 32'h0);
		edges_in(400, s0);
		chk(32'(s0 >= 90), 32'h1);
		power_pin <= 1'b0;
		edges_in(400, s0);
		chk(32'(s0 >= 4), 32'h1);
		power_pin <= 1'b1;
		line_pos <= 14'h1234;
		line_neg <= 14'h0321;
		tick(40);
		chk(32'({pos, neg}), 32'({14'h1234, 14'h0321}));
		bus(1'b1, ADDR_CONTROL, 32'h4);
		tick(40);
		chk(32'({pos, neg}), 32'({14'h1335, 14'h0000}));
		line_violation <= 14'h0004;
		tick(40);
		chk(32'(neg), 32'h4);
		tick(200);
		chk(32'(neg), 32'h4);
		bus(1'b1, ADDR_COUNTER_CLEAR, 32'h3FFF);
		bus(1'b1, ADDR_CONTROL, 32'hC);
		tick(40);
		chk(32'(neg), 32'h0);
		line_violation <= 14'h0000;
		bus(1'b1, ADDR_CONTROL, 32'h4);
		tick(40);
		chk(32'(neg), 32'h0);
		line_los <= 14'h0008;
		tick(8);
		chk(32'({summary, irq}), 32'h2);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h8);
		bus(1'b0, ADDR_LIVE, 32'h0);
		chk(rd, 32'h8);
		bus(1'b1, ADDR_MASK, 32'h8);
		tick(4);
		chk(32'(irq), 32'h1);
		line_los <= 14'h0000;
		tick(100);
		chk(32'(summary), 32'h1);
		tick(100);
		chk(32'(summary), 32'h0);
		bus(1'b1, ADDR_STATUS, 32'h8);
		tick(4);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_CONTROL, 32'h0);
		toggling <= 1'b1;
		tick(20);
		s0 = rise_updates;
		s1 = fall_updates;
		tick(600);
		chk(32'({rise_updates > s0, fall_updates == s1}), 32'h3);
		bus(1'b1, ADDR_CONTROL, 32'h2);
		tick(20);
		s0 = rise_updates;
		s1 = fall_updates;
		tick(600);
		chk(32'({rise_updates == s0, fall_updates > s1}), 32'h3);
		finish_test();
	end
endmodule : liu_receive_output_control_test
